// File: bench/vibration_suppress_notch_ctrl_bench.sv
// Self-checking bench of the suppression stage and notch control.
`timescale 1ns/1ns
`default_nettype none
module vibration_suppress_notch_ctrl_bench;
  import vsn_pkg::*;
  localparam int WF = 20;
  localparam int WS = 50;
  logic pclk, presetn, psel, penable, pwrite, move, pready, pslverr, e;
  logic motor_moving, servo_lock, est_valid, est_ok, est_stage2, est_single, est_single_stage2;
  logic stage1_en, stage2_en, notch_en;
  logic [15:0] est_vib_freq, est_res_freq, est_vib_damping, est_res_damping;
  logic [7:0] paddr, notch_freq_sel;
  logic [3:0] notch_depth_sel;
  logic [31:0] pwdata, prdata, r;
  logic [127:0] so;
  logic [63:0] v;
  logic [12:0] ap;
  int bad_count, total_checks, cyc, p[8], code, dep, w;
  int nc[5] = '{8'h10, 8'h7F, 8'h20, 8'h90, 8'h00};
  vsn_ctrl #(.WAIT_FAST(WF), .WAIT_SLOW(WS)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motor_moving(motor_moving), .servo_lock(servo_lock), .est_valid(est_valid),
    .est_ok(est_ok), .est_stage2(est_stage2), .est_single(est_single),
    .est_single_stage2(est_single_stage2), .est_vib_freq(est_vib_freq),
    .est_res_freq(est_res_freq), .est_vib_damping(est_vib_damping),
    .est_res_damping(est_res_damping), .stage1_en(stage1_en), .stage2_en(stage2_en),
    .notch_en(notch_en), .notch_freq_sel(notch_freq_sel), .notch_depth_sel(notch_depth_sel),
    .stage1_vib_freq(so[127:112]), .stage1_res_freq(so[111:96]),
    .stage1_vib_damping(so[95:80]), .stage1_res_damping(so[79:64]),
    .stage2_vib_freq(so[63:48]), .stage2_res_freq(so[47:32]),
    .stage2_vib_damping(so[31:16]), .stage2_res_damping(so[15:0]));
  vsn_servo_model sm (
    .pclk(pclk), .presetn(presetn), .move(move), .motor_moving(motor_moving),
    .servo_lock(servo_lock), .est_valid(est_valid), .est_ok(est_ok), .est_stage2(est_stage2),
    .est_single(est_single), .est_single_stage2(est_single_stage2),
    .est_vib_freq(est_vib_freq), .est_res_freq(est_res_freq),
    .est_vib_damping(est_vib_damping), .est_res_damping(est_res_damping));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic st(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic stages(input logic x1, input logic x2);
    st(3);
    chk(stage1_en, x1);
    chk(stage2_en, x2);
    for (int i = 0; i < 8; i++) chk(so[127-16*i -: 16], p[i]);
  endtask
  task automatic est(input logic ok, s2, sg, sg2, input logic upd);
    for (int k = 0; k < 4; k++) v[16*k +: 16] = 16'($urandom_range(16'h1000, 16'h100));
    sm.fire(ok, s2, sg, sg2, v);
    if (upd) for (int k = 0; k < 4; k++) p[4*s2 + k] = v[63-16*k -: 16];
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, move, paddr, pwdata} = '0;
    void'($urandom(32'h67f99fd5));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    stages(0, 0);
    chk(notch_en, 0);
    for (int a = 0; a <= 'h30; a += 4) begin
      apb(0, 8'(a), 0);
      chk({e, r}, 0);
    end
    apb(0, 8'h40, 0);
    chk({e, r}, 33'h100000000);
    apb(1, OFF_STATUS, 32'hFFFFFFFF);
    chk(e, 1);
    for (int i = 0; i < 8; i++) begin
      p[i] = $urandom_range(16'h1000, 16'h100);
      apb(1, 8'(OFF_PARAM + 4 * i), p[i]);
      apb(0, 8'(OFF_PARAM + 4 * i), 0);
      chk(r, p[i]);
    end
    apb(1, OFF_MODE, 1);
    for (int m = 0; m < 16; m++) begin
      apb(1, OFF_TUNING, 32'((m / 4) * 16 + m % 4));
      stages(m % 4 inside {1, 2}, m / 4 inside {1, 2});
    end
    apb(1, OFF_TUNING, 32'h11);
    est(1, 0, 0, 0, 1);
    stages(1, 1);
    apb(0, OFF_STATUS, 0);
    chk(r[6:0], 7'h6B);
    est(0, 1, 0, 0, 0);
    stages(1, 1);
    apb(0, OFF_STATUS, 0);
    chk(r[6:0], 7'h73);
    est(1, 1, 0, 0, 1);
    stages(1, 1);
    est(1, 0, 1, 1, 1);
    stages(0, 1);
    apb(1, OFF_TUNING, 32'h12);
    est(1, 0, 1, 1, 0);
    stages(1, 1);
    apb(1, OFF_GAIN, 32'hFFFF);
    stages(0, 0);
    apb(0, OFF_STATUS, 0);
    chk(r[6:0], 7'h08);
    ap = '0;
    for (int i = 0; i < 5; i++) begin
      code = (nc[i] > 'h7F) ? 'h7F : nc[i];
      dep = $urandom_range(15, 0);
      move <= 1'b1;
      apb(1, OFF_NOTCH, 32'(dep * 256 + nc[i]));
      st(WS + 5);
      chk({notch_en, notch_depth_sel, notch_freq_sel}, ap);
      w = (ap[7:0] >= 8'h60) ? WS : WF;
      move <= 1'b0;
      st(w + 1);
      chk({notch_en, notch_depth_sel, notch_freq_sel}, ap);
      ap = {code != 0, 4'(dep), 8'(code)};
      st(4);
      chk({notch_en, notch_depth_sel, notch_freq_sel}, ap);
      apb(0, OFF_STATUS, 0);
      chk(r & 32'h000FFF04, {12'h000, ap[11:0], 8'h00});
    end
    give_verdict();
  end
endmodule
`default_nettype wire

// File: bench/vsn_ctrl_assertions.sv
// Port-level checker of notch apply timing and stage control.
`timescale 1ns/1ns
`default_nettype none
module vsn_ctrl_assertions #(
  parameter int WAIT_FAST = 20,
  parameter int WAIT_SLOW = 50
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        motor_moving,
  input wire logic        servo_lock,
  input wire logic        est_valid,
  input wire logic        est_ok,
  input wire logic [15:0] stage1_vib_freq,
  input wire logic [15:0] stage2_vib_freq,
  input wire logic        stage1_en,
  input wire logic        stage2_en,
  input wire logic        notch_en,
  input wire logic [7:0]  notch_freq_sel
);
  int lck;
  // Counts locked standstill cycles; saturates so a long idle run cannot wrap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lck <= 0;
    end else begin
      lck <= (servo_lock && !motor_moving) ? ((lck < WAIT_SLOW) ? lck + 1 : lck) : 0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no answer in access cycle");
  property p_en_code; notch_en == (notch_freq_sel != 8'h00); endproperty
  a_en_code: assert property (p_en_code) else $error("notch enable wrong");
  property p_range; notch_freq_sel <= 8'h7F; endproperty
  a_range: assert property (p_range) else $error("notch code out of range");
  property p_hold; motor_moving |=> $stable(notch_freq_sel); endproperty
  a_hold: assert property (p_hold) else $error("notch applied in motion");
  property p_wait;
    $changed(notch_freq_sel)
      |-> lck >= (($past(notch_freq_sel) >= 8'h60) ? WAIT_SLOW : WAIT_FAST);
  endproperty
  a_wait: assert property (p_wait) else $error("notch applied too early");
  property p_fail;
    est_valid && !est_ok && !psel |=> $stable(stage1_vib_freq) && $stable(stage2_vib_freq);
  endproperty
  a_fail: assert property (p_fail) else $error("failed estimate stored");
  property p_src; !est_valid && !(psel && pwrite) |=> $stable(stage1_vib_freq); endproperty
  a_src: assert property (p_src) else $error("parameter changed alone");
  property p_stage;
    (!est_valid && !(psel && pwrite))[*3] |=> $stable(stage1_en) && $stable(stage2_en);
  endproperty
  a_stage: assert property (p_stage) else $error("stage enable changed alone");
endmodule
bind vsn_ctrl vsn_ctrl_assertions #(
  .WAIT_FAST(WAIT_FAST),
  .WAIT_SLOW(WAIT_SLOW)
) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .motor_moving(motor_moving), .servo_lock(servo_lock),
  .est_valid(est_valid), .est_ok(est_ok), .stage1_vib_freq(stage1_vib_freq),
  .stage2_vib_freq(stage2_vib_freq), .stage1_en(stage1_en), .stage2_en(stage2_en),
  .notch_en(notch_en), .notch_freq_sel(notch_freq_sel)
);
`default_nettype wire

// File: bench/vsn_servo_model.sv
// Servo loop and estimator stand-in at the block's far side.
`timescale 1ns/1ns
`default_nettype none
module vsn_servo_model (
  input wire logic  pclk,
  input wire logic  presetn,
  input wire logic  move,
  output logic      motor_moving,
  output logic      servo_lock,
  output logic      est_valid,
  output logic      est_ok,
  output logic      est_stage2,
  output logic      est_single,
  output logic      est_single_stage2,
  output logic [15:0] est_vib_freq,
  output logic [15:0] est_res_freq,
  output logic [15:0] est_vib_damping,
  output logic [15:0] est_res_damping
);
  // Lock comes one cycle after standstill, as a real loop settles first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_moving <= 1'b0;
      servo_lock <= 1'b0;
    end else begin
      motor_moving <= move;
      servo_lock <= !move && !motor_moving;
    end
  end
  initial begin
    est_valid = 1'b0;
    {est_ok, est_stage2, est_single, est_single_stage2} = 4'h0;
    {est_vib_freq, est_res_freq, est_vib_damping, est_res_damping} = 64'h0;
  end
  // Values are inverted after the pulse, so a stale read cannot pass.
  task automatic fire(input logic ok, s2, sg, sg2, input logic [63:0] v);
    @(posedge pclk);
    est_valid <= 1'b1;
    {est_ok, est_stage2, est_single, est_single_stage2} <= {ok, s2, sg, sg2};
    {est_vib_freq, est_res_freq, est_vib_damping, est_res_damping} <= v;
    @(posedge pclk);
    est_valid <= 1'b0;
    {est_ok, est_stage2, est_single, est_single_stage2} <= ~{ok, s2, sg, sg2};
    {est_vib_freq, est_res_freq, est_vib_damping, est_res_damping} <= ~v;
  endtask
endmodule
`default_nettype wire

// File: rtl/unused_placeholder_none.sv
// Intentionally empty compilation unit kept out of the build.

// File: rtl/vsn_ctrl.sv
// Vibration suppression stage control and command notch apply logic behind an APB slave.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none

module vsn_ctrl
  import vsn_pkg::*;
#(
  parameter int WAIT_FAST = WAIT_FAST_CYC,
  parameter int WAIT_SLOW = WAIT_SLOW_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        motor_moving,
  input  wire logic        servo_lock,
  input  wire logic        est_valid,
  input  wire logic        est_ok,
  input  wire logic        est_stage2,
  input  wire logic        est_single,
  input  wire logic        est_single_stage2,
  input  wire logic [15:0] est_vib_freq,
  input  wire logic [15:0] est_res_freq,
  input  wire logic [15:0] est_vib_damping,
  input  wire logic [15:0] est_res_damping,
  output logic             stage1_en,
  output logic             stage2_en,
  output logic      [15:0] stage1_vib_freq,
  output logic      [15:0] stage1_res_freq,
  output logic      [15:0] stage1_vib_damping,
  output logic      [15:0] stage1_res_damping,
  output logic      [15:0] stage2_vib_freq,
  output logic      [15:0] stage2_res_freq,
  output logic      [15:0] stage2_vib_damping,
  output logic      [15:0] stage2_res_damping,
  output logic             notch_en,
  output logic      [7:0]  notch_freq_sel,
  output logic      [3:0]  notch_depth_sel
);

  ////////////////////////////////////////////////////////////////////////////////
  logic                    suppress_mode_sel;
  logic [1:0]              stage1_tuning_sel;
  logic [1:0]              stage2_tuning_sel;
  logic [15:0]             model_loop_gain;
  logic [15:0]             prm [NUM_PARAM];
  logic [7:0]              pend_freq;
  logic [3:0]              pend_depth;
  logic                    pending;
  logic                    est_done;
  logic                    est_fail;
  logic                    single_opt;
  logic                    single_s2;
  logic                    gain_ok1;
  logic                    gain_ok2;
  logic [19:0]             vib1_scaled;
  logic [19:0]             res1_scaled;
  logic [19:0]             vib2_scaled;
  logic [19:0]             res2_scaled;
  logic [19:0]             gain_ref1;
  logic [19:0]             gain_ref2;
  vsn_state_t              state;
  logic [31:0]             wait_cnt;
  logic                    setup;
  logic                    wr_en;
  logic                    mapped;
  logic                    param_hit;
  logic [2:0]              param_idx;
  logic [7:0]              param_ofs;
  logic [31:0]             rd_mux;
  logic                    s1_req;
  logic                    s2_req;
  logic                    both_auto;
  logic                    est_take1;
  logic                    est_take2;

  ////////////////////////////////////////////////////////////////////////////////
  // Zero-wait slave: the setup cycle registers the answer, the access cycle carries it.
  assign setup     = psel && !penable;
  assign wr_en     = psel && penable && pready && pwrite && !pslverr;
  assign param_ofs = paddr - OFF_PARAM;
  assign param_hit = (paddr >= OFF_PARAM) && (paddr < OFF_NOTCH) && (paddr[1:0] == 2'h0);
  assign param_idx = param_ofs[4:2];
  assign mapped    = param_hit || (paddr == OFF_MODE) || (paddr == OFF_TUNING)
                     || (paddr == OFF_GAIN) || (paddr == OFF_NOTCH)
                     || (paddr == OFF_STATUS);

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (param_hit) begin
      rd_mux = {16'h0000, prm[param_idx]};
    end else if (paddr == OFF_MODE) begin
      rd_mux = {31'h0000_0000, suppress_mode_sel};
    end else if (paddr == OFF_TUNING) begin
      rd_mux[TUNE1_LSB+:2] = stage1_tuning_sel;
      rd_mux[TUNE2_LSB+:2] = stage2_tuning_sel;
    end else if (paddr == OFF_GAIN) begin
      rd_mux = {16'h0000, model_loop_gain};
    end else if (paddr == OFF_NOTCH) begin
      rd_mux[7:0]           = pend_freq;
      rd_mux[DEPTH_LSB+:4]  = pend_depth;
    end else if (paddr == OFF_STATUS) begin
      rd_mux = {12'h000, notch_depth_sel, notch_freq_sel,
                1'b0, gain_ok2, gain_ok1, est_fail, est_done, pending, stage2_en, stage1_en};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= !mapped || (pwrite && paddr == OFF_STATUS);
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      suppress_mode_sel <= 1'b0;
      stage1_tuning_sel <= TUNE_OFF;
      stage2_tuning_sel <= TUNE_OFF;
      model_loop_gain   <= RST_GAIN;
    end else if (wr_en) begin
      if (paddr == OFF_MODE) begin
        suppress_mode_sel <= pwdata[0];
      end
      if (paddr == OFF_TUNING) begin
        stage1_tuning_sel <= pwdata[TUNE1_LSB+:2];
        stage2_tuning_sel <= pwdata[TUNE2_LSB+:2];
      end
      if (paddr == OFF_GAIN) begin
        model_loop_gain <= pwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Estimates are only stored for a stage in automatic mode and only when valid. [RL3] [RL4] [RL8]
  assign est_take1 = est_valid && est_ok && !est_stage2 && stage1_tuning_sel == TUNE_AUTO;
  assign est_take2 = est_valid && est_ok && est_stage2 && stage2_tuning_sel == TUNE_AUTO;

  // Each stage owns four values; the estimator wins over a bus write in the same cycle. [RL6]
  // Values are applied live, so the host must not write them while the motor moves. [RL7]
  generate
    for (genvar i = 0; i < NUM_PARAM; i++) begin : g_prm
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prm[i] <= RST_PARAM;
        end else if ((i < 4) ? est_take1 : est_take2) begin
          unique case (i % 4)
            0: prm[i] <= est_vib_freq;
            1: prm[i] <= est_res_freq;
            2: prm[i] <= est_vib_damping;
            3: prm[i] <= est_res_damping;
          endcase
        end else if (wr_en && param_hit && param_idx == 3'(i)) begin
          prm[i] <= pwdata[15:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      est_done   <= 1'b0;
      est_fail   <= 1'b0;
      single_opt <= 1'b0;
      single_s2  <= 1'b0;
    end else if (est_valid) begin
      est_done   <= est_ok;
      est_fail   <= !est_ok;
      single_opt <= est_ok && est_single;
      single_s2  <= est_single_stage2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Stage frequencies are checked against the model loop gain; the notch is not. [RL13]
  // Products are kept 20 bits wide so ten times a full-scale frequency cannot wrap.
  assign vib1_scaled = 20'(prm[0]) * GAIN_K1;
  assign res1_scaled = 20'(prm[1]) * GAIN_K1;
  assign vib2_scaled = 20'(prm[4]) * GAIN_K2;
  assign res2_scaled = 20'(prm[5]) * GAIN_K2;
  assign gain_ref1   = 20'(model_loop_gain);
  assign gain_ref2   = 20'(model_loop_gain) + GAIN_OFS2;
  assign gain_ok1    = (vib1_scaled > gain_ref1) && (res1_scaled > gain_ref1); // [RL13]
  assign gain_ok2    = (vib2_scaled > gain_ref2) && (res2_scaled > gain_ref2); // [RL13]

  // Stage 2 exists only in three-inertia mode. [RL1] [RL3] [RL4]
  assign s1_req    = stage1_tuning_sel == TUNE_AUTO || stage1_tuning_sel == TUNE_MANUAL;
  assign s2_req    = suppress_mode_sel
                     && (stage2_tuning_sel == TUNE_AUTO || stage2_tuning_sel == TUNE_MANUAL);
  assign both_auto = suppress_mode_sel && stage1_tuning_sel == TUNE_AUTO
                     && stage2_tuning_sel == TUNE_AUTO;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_en <= 1'b0;
      stage2_en <= 1'b0;
    end else if (both_auto && single_opt) begin
      stage1_en <= !single_s2 && gain_ok1; // [RL5]
      stage2_en <= single_s2 && gain_ok2; // [RL5]
    end else begin
      stage1_en <= s1_req && gain_ok1; // [RL1] [RL14]
      stage2_en <= s2_req && gain_ok2; // [RL14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // A code above the table's last entry is clamped so the range stays 1.12 Hz to 2 kHz. [RL10]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_freq  <= RST_FREQ_CODE;
      pend_depth <= RST_DEPTH;
    end else if (wr_en && paddr == OFF_NOTCH) begin
      pend_freq  <= (pwdata[7:0] > FREQ_CODE_MAX) ? FREQ_CODE_MAX : pwdata[7:0]; // [RL10] [RL15]
      pend_depth <= pwdata[DEPTH_LSB+:4]; // [RL16]
    end
  end

  // A new write restarts the wait, so the last written setting is the one applied.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= VSN_IDLE;
      pending  <= 1'b0;
      wait_cnt <= 32'h0000_0000;
    end else if (wr_en && paddr == OFF_NOTCH) begin
      state    <= VSN_WAIT_LOCK; // [RL11]
      pending  <= 1'b1;
      wait_cnt <= 32'h0000_0000;
    end else begin
      unique case (state)
        VSN_IDLE: begin
          pending <= 1'b0;
        end
        VSN_WAIT_LOCK: begin
          if (servo_lock && !motor_moving) begin
            state <= VSN_DELAY; // [RL11]
            // Old codes of 60 and up lie below 4.5 Hz and need the long wait. [RL12]
            wait_cnt <= (notch_freq_sel >= FREQ_CODE_LOW) ? 32'(WAIT_SLOW - 1)
                                                          : 32'(WAIT_FAST - 1);
          end
        end
        VSN_DELAY: begin
          if (motor_moving || !servo_lock) begin
            state <= VSN_WAIT_LOCK; // [RL11]
          end else if (wait_cnt == 32'h0000_0000) begin
            state   <= VSN_IDLE; // [RL12]
            pending <= 1'b0;
          end else begin
            wait_cnt <= wait_cnt - 32'h0000_0001; // [RL12]
          end
        end
        default: begin
          // A stray state code falls back to idle instead of hanging the apply path.
          state   <= VSN_IDLE;
          pending <= 1'b0;
        end
      endcase
    end
  end

  // The notch setting feeds the command path on its own and needs no estimate. [RL9] [RL14]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      notch_freq_sel  <= RST_FREQ_CODE;
      notch_depth_sel <= RST_DEPTH;
      notch_en        <= 1'b0;
    end else if (state == VSN_DELAY && servo_lock && !motor_moving
                 && wait_cnt == 32'h0000_0000 && !(wr_en && paddr == OFF_NOTCH)) begin
      notch_freq_sel  <= pend_freq; // [RL9] [RL12]
      notch_depth_sel <= pend_depth; // [RL16]
      notch_en        <= pend_freq != RST_FREQ_CODE; // [RL15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign stage1_vib_freq    = prm[0];
  assign stage1_res_freq    = prm[1];
  assign stage1_vib_damping = prm[2];
  assign stage1_res_damping = prm[3];
  assign stage2_vib_freq    = prm[4];
  assign stage2_res_freq    = prm[5];
  assign stage2_vib_damping = prm[6];
  assign stage2_res_damping = prm[7];

endmodule

`default_nettype wire

// File: rtl/vsn_pkg.sv
// Constants, register map and reset values of the vibration suppression control block.
// What this block does
// RL1: Stage 1 runs when its tuning field selects automatic setting.
// RL2: Host selects three-inertia mode and automatic tuning for both stages to use both.
// RL3: Stage 1 tuning field: 0 off, 1 estimator writes its four values, 2 manual.
// RL4: Stage 2 tuning field decodes the same way for its own four values.
// RL5: With both stages automatic, estimator may judge one stage optimal and enable only it.
// RL6: Each stage has its own vibration, resonance and two damping values.
// RL7: Host changes suppression values only while the motor stands still.
// RL8: Estimation may fail on small residual vibration; results are then not trusted.
// RL9: Notch filter cuts one chosen command frequency at a chosen depth, no estimation.
// RL10: Notch frequency range is 1.12 Hz to 2000 Hz only.
// RL11: A notch change during a move stays pending until stop and servo-lock.
// RL12: After servo-lock apply after 150 ms, or 500 ms if old frequency under 4.5 Hz.
// RL13: Stages are limited against model loop gain; the notch filter is not.
// RL14: Both stages and the notch filter work together on three frequencies.
// RL15: Notch frequency code 00 disables, 01 highest, 7F lowest frequency.
// RL16: Notch depth code 0 is deepest at -40 dB, shallower up to F.
package vsn_pkg;

  localparam logic [7:0]  OFF_MODE      = 8'h00;
  localparam logic [7:0]  OFF_TUNING    = 8'h04;
  localparam logic [7:0]  OFF_GAIN      = 8'h08;
  localparam logic [7:0]  OFF_PARAM     = 8'h0C;
  localparam logic [7:0]  OFF_NOTCH     = 8'h2C;
  localparam logic [7:0]  OFF_STATUS    = 8'h30;
  localparam int          NUM_PARAM     = 8;

  localparam int          TUNE1_LSB     = 0;
  localparam int          TUNE2_LSB     = 4;
  localparam int          DEPTH_LSB     = 8;

  localparam logic [1:0]  TUNE_OFF      = 2'h0;
  localparam logic [1:0]  TUNE_AUTO     = 2'h1;
  localparam logic [1:0]  TUNE_MANUAL   = 2'h2;

  localparam logic [15:0] RST_PARAM     = 16'h0000;
  localparam logic [15:0] RST_GAIN      = 16'h0000;
  localparam logic [7:0]  RST_FREQ_CODE = 8'h00;
  localparam logic [3:0]  RST_DEPTH     = 4'h0;

  localparam logic [7:0]  FREQ_CODE_MAX = 8'h7F;
  localparam logic [7:0]  FREQ_CODE_LOW = 8'h60;

  localparam logic [19:0] GAIN_K1       = 20'h00007;
  localparam logic [19:0] GAIN_K2       = 20'h0000A;
  localparam logic [19:0] GAIN_OFS2     = 20'h00032;

  localparam int          CLK_MHZ       = 250;
  localparam int          WAIT_FAST_MS  = 150;
  localparam int          WAIT_SLOW_MS  = 500;
  localparam int          WAIT_FAST_CYC = WAIT_FAST_MS * 1000 * CLK_MHZ;
  localparam int          WAIT_SLOW_CYC = WAIT_SLOW_MS * 1000 * CLK_MHZ;

  typedef enum logic [1:0] {
    VSN_IDLE,
    VSN_WAIT_LOCK,
    VSN_DELAY
  } vsn_state_t;

endpackage
